/* File: hdl/pstat_mode_track.sv */
// Mode tracker: turns the mode requests into a one-hot state and code.
// Assumes requests come from logic on i_clk_sys; test outranks programming.
`timescale 1ns/100ps
module pstat_mode_track
  import pstat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_mode_programming,
  input wire logic i_mode_test,
  output logic [3:0] o_device_mode_code
);
  `include "pstat_params.svh"

  pstat_mode_e state_q;
  pstat_mode_e state_d;

  // Next mode; test mode wins over programming, operating when neither is requested
  always_comb begin
    if (i_mode_test) begin
      state_d = PSTAT_MODE_TST;
    end else if (i_mode_programming) begin
      state_d = PSTAT_MODE_PRG;
    end else begin
      state_d = PSTAT_MODE_OP;
    end
  end

  // Mode state
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q <= PSTAT_MODE_OP;
    end else begin
      state_q <= state_d;
    end
  end

  // Code presented to the host, decoded from the held state; reset state is operating
  always_comb begin
    case (state_q)
      PSTAT_MODE_OP: o_device_mode_code = `PSTAT_MODE_OPERATING;
      PSTAT_MODE_PRG: o_device_mode_code = `PSTAT_MODE_PROGRAMMING;
      PSTAT_MODE_TST: o_device_mode_code = `PSTAT_MODE_TEST;
      default: o_device_mode_code = `PSTAT_MODE_OPERATING;
    endcase
  end
endmodule

/* File: hdl/pstat_regs.sv */
// Read-only status and option bank reached by register read/write strobes.
// Assumes the serial front end decodes frames into i_acc, one access per cycle,
// and all live status inputs come from logic on i_clk_sys.
`timescale 1ns/100ps
module pstat_regs
  import pstat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire pstat_acc_s i_acc,
  input wire pstat_live_s i_live,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_addr_err,
  output logic [7:0] o_watchdog_fault_tally,
  output logic [7:0] o_programming_support_state,
  output logic [7:0] o_step_down2_output_setting,
  output logic [7:0] o_hardware_option_detect
);
  `include "pstat_params.svh"

  // ----------------------------------------
  // Field holding registers
  // ----------------------------------------
  logic [3:0] watchdog_error_level_q;
  logic [3:0] step_down2_coarse_code_q;
  logic [3:0] step_down2_fine_code_q;
  // Option bits in register order, monitor two first; one flop each
  localparam int OPTION_COUNT = 5;
  logic [OPTION_COUNT-1:0] option_q;
  logic [OPTION_COUNT-1:0] option_live;
  logic [3:0] device_mode_code;

  // Address decode, used by the error flag only; read data selects in image_at
  function automatic logic is_mapped(input logic [6:0] addr);
    is_mapped = (addr == `PSTAT_OFS_WATCHDOG_FAULT_TALLY) ||
                (addr == `PSTAT_OFS_PROGRAMMING_SUPPORT_STATE) ||
                (addr == `PSTAT_OFS_STEP_DOWN2_OUTPUT_SETTING) ||
                (addr == `PSTAT_OFS_HARDWARE_OPTION_DETECT);
  endfunction

  // Coarse code check; codes past the table name no voltage
  function automatic logic coarse_legal(input logic [3:0] code);
    coarse_legal = (code <= `PSTAT_COARSE_MAX);
  endfunction

  // Fine code check; codes past the table name no voltage
  function automatic logic fine_legal(input logic [3:0] code);
    fine_legal = (code <= `PSTAT_FINE_MAX);
  endfunction

  // Image select by offset; anything unmapped reads as zero
  function automatic logic [7:0] image_at(input logic [6:0] addr, input logic [7:0] wdt,
                                          input logic [7:0] mode, input logic [7:0] b2,
                                          input logic [7:0] hw);
    case (addr)
      `PSTAT_OFS_WATCHDOG_FAULT_TALLY: image_at = wdt;
      `PSTAT_OFS_PROGRAMMING_SUPPORT_STATE: image_at = mode;
      `PSTAT_OFS_STEP_DOWN2_OUTPUT_SETTING: image_at = b2;
      `PSTAT_OFS_HARDWARE_OPTION_DETECT: image_at = hw;
      default: image_at = 8'h00;
    endcase
  endfunction

  // Mode code comes from its own tracker
  pstat_mode_track u_mode (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_mode_programming(i_live.mode_programming),
    .i_mode_test(i_live.mode_test),
    .o_device_mode_code(device_mode_code)
  );

  // Watchdog count sampled each cycle; 4 bits so never above 15
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      watchdog_error_level_q <= `PSTAT_RST_WATCHDOG_ERROR_LEVEL;
    end else begin
      watchdog_error_level_q <= i_live.watchdog_error_level;
    end
  end

  // Coarse step-down2 code; a code past the table holds the last legal one,
  // so the host never reads a setting that names no voltage
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      step_down2_coarse_code_q <= `PSTAT_RST_COARSE;
    end else if (coarse_legal(i_live.step_down2_coarse_code)) begin
      step_down2_coarse_code_q <= i_live.step_down2_coarse_code;
    end
  end

  // Fine step-down2 code; same hold rule as the coarse code
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      step_down2_fine_code_q <= `PSTAT_RST_FINE;
    end else if (fine_legal(i_live.step_down2_fine_code)) begin
      step_down2_fine_code_q <= i_live.step_down2_fine_code;
    end
  end

  // ----------------------------------------
  // Option detection bits
  // ----------------------------------------
  // Live option levels gathered in register order
  always_comb begin
    option_live[4] = i_live.monitor_two_used;
    option_live[3] = i_live.monitor_one_used;
    option_live[2] = i_live.step_up_used;
    option_live[1] = i_live.step_down2_used;
    option_live[0] = i_live.switching_band_select;
  end

  // One flop per option; all read as set until the first sample after reset
  for (genvar b = 0; b < OPTION_COUNT; b++) begin : g_option
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        option_q[b] <= `PSTAT_RST_OPTION_BIT;
      end else begin
        option_q[b] <= option_live[b];
      end
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  logic [7:0] img_wdt;
  logic [7:0] img_mode;
  logic [7:0] img_b2;
  logic [7:0] img_hw;

  // Assembled images; unused bits tied low
  always_comb begin
    img_wdt = {4'h0, watchdog_error_level_q};
    img_mode = {4'h0, device_mode_code};
    img_b2 = {step_down2_coarse_code_q, step_down2_fine_code_q};
    img_hw = 8'h00;
    img_hw[`PSTAT_BIT_MONITOR_TWO_USED] = option_q[4];
    img_hw[`PSTAT_BIT_MONITOR_ONE_USED] = option_q[3];
    img_hw[`PSTAT_BIT_STEP_UP_USED] = option_q[2];
    img_hw[`PSTAT_BIT_STEP_DOWN2_USED] = option_q[1];
    img_hw[`PSTAT_BIT_SWITCHING_BAND_SELECT] = option_q[0];
  end

  // ----------------------------------------
  // Register copies seen by the rest of the chip
  // ----------------------------------------
  // No write path exists anywhere below, so host writes change nothing
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_watchdog_fault_tally <= {4'h0, `PSTAT_RST_WATCHDOG_ERROR_LEVEL};
    end else begin
      o_watchdog_fault_tally <= img_wdt;
    end
  end

  // Mode image; reset shows the operating code
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_programming_support_state <= {4'h0, `PSTAT_MODE_OPERATING};
    end else begin
      o_programming_support_state <= img_mode;
    end
  end

  // Step-down2 image; reset is coarse 0 with the default fine code
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_step_down2_output_setting <= {`PSTAT_RST_COARSE, `PSTAT_RST_FINE};
    end else begin
      o_step_down2_output_setting <= img_b2;
    end
  end

  // Option image; reset reads every option as present, high band
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_hardware_option_detect <= `PSTAT_RST_HARDWARE_OPTION_DETECT;
    end else begin
      o_hardware_option_detect <= img_hw;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read strobe echoed one cycle later; writes never raise it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_acc.rd;
    end
  end

  // Error pulse for any strobe outside the map, reads and writes alike
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_addr_err <= 1'b0;
    end else begin
      o_addr_err <= (i_acc.rd | i_acc.wr) & ~is_mapped(i_acc.addr);
    end
  end

  // Read data stands only in the valid cycle and is zero otherwise, so a
  // stale value cannot be mistaken for an answer
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_acc.rd) begin
      o_rdata <= image_at(i_acc.addr, img_wdt, img_mode, img_b2, img_hw);
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

/* File: include/pstat_params.svh */
// Offsets, field positions and reset values of the status bank.
// Assumes inclusion by bare name from the package and design files.
`ifndef PSTAT_PARAMS_SVH
`define PSTAT_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSTAT_OFS_WATCHDOG_FAULT_TALLY 7'h2A
`define PSTAT_OFS_PROGRAMMING_SUPPORT_STATE 7'h37
`define PSTAT_OFS_STEP_DOWN2_OUTPUT_SETTING 7'h39
`define PSTAT_OFS_HARDWARE_OPTION_DETECT 7'h3B
// ----------------------------------------
// Field positions in hardware_option_detect
// ----------------------------------------
`define PSTAT_BIT_MONITOR_TWO_USED 7
`define PSTAT_BIT_MONITOR_ONE_USED 6
`define PSTAT_BIT_STEP_UP_USED 4
`define PSTAT_BIT_STEP_DOWN2_USED 1
`define PSTAT_BIT_SWITCHING_BAND_SELECT 0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define PSTAT_RST_WATCHDOG_ERROR_LEVEL 4'h0
`define PSTAT_MODE_OPERATING 4'h3
`define PSTAT_MODE_PROGRAMMING 4'h6
`define PSTAT_MODE_TEST 4'h9
`define PSTAT_RST_COARSE 4'h0
`define PSTAT_RST_FINE 4'h2
`define PSTAT_COARSE_MAX 4'h4
`define PSTAT_FINE_MAX 4'h8
`define PSTAT_RST_OPTION_BIT 1'b1
`define PSTAT_RST_HARDWARE_OPTION_DETECT 8'hD3
`endif

/* File: include/pstat_pkg.sv */
// Types shared by the status bank and its field sampler.
// Assumes pstat_params.svh is on the include path.
package pstat_pkg;
  `include "pstat_params.svh"

  // Operating, programming and test modes
  typedef enum logic [2:0] {
    PSTAT_MODE_OP = 3'b001,
    PSTAT_MODE_PRG = 3'b010,
    PSTAT_MODE_TST = 3'b100
  } pstat_mode_e;

  // Live status gathered from the rest of the chip
  typedef struct packed {
    logic [3:0] watchdog_error_level;
    logic mode_programming;
    logic mode_test;
    logic [3:0] step_down2_coarse_code;
    logic [3:0] step_down2_fine_code;
    logic monitor_two_used;
    logic monitor_one_used;
    logic step_up_used;
    logic step_down2_used;
    logic switching_band_select;
  } pstat_live_s;

  // Register read or write access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } pstat_acc_s;
endpackage

/* File: verification/pstat_host.sv */
// Host model: one register access at a time on the strobes.
// Assumes the bank's clock; the testbench calls xfer.
`timescale 1ns/100ps
module pstat_host
  import pstat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_addr_err,
  output pstat_acc_s o_acc
);
  initial o_acc = '0;
  // One-cycle strobe; answer taken one edge after the bank saw it
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e, output logic v);
    @(posedge i_clk_sys);
    o_acc <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge i_clk_sys);
    o_acc <= '0;
    @(posedge i_clk_sys);
    q = i_rdata;
    e = i_addr_err;
    v = i_rvalid;
  endtask
endmodule

/* File: verification/pstat_regs_asserts.sv */
// Checker for the status bank, bound to pstat_regs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module pstat_regs_asserts
  import pstat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire pstat_acc_s i_acc,
  input wire pstat_live_s i_live,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_addr_err,
  input wire logic [7:0] o_watchdog_fault_tally,
  input wire logic [7:0] o_programming_support_state,
  input wire logic [7:0] o_step_down2_output_setting,
  input wire logic [7:0] o_hardware_option_detect
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  logic mapped;
  // Address decode of the four registers
  assign mapped = i_acc.addr inside {7'h2A, 7'h37, 7'h39, 7'h3B};
  // --------
  // Rules
  // --------
  a_write_silent: assert property (i_acc.wr && !i_acc.rd |=> !o_rvalid)
    else $error("write produced read data");
  a_unmapped_err: assert property ((i_acc.rd || i_acc.wr) && !mapped |=> o_addr_err)
    else $error("unmapped access without error");
  a_unmapped_zero: assert property (i_acc.rd && !mapped |=> o_rvalid && o_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Two-edge path from live level to image
  a_tally_live: assert property (!$past(i_reset) && !$past(i_reset, 2) |->
    o_watchdog_fault_tally == {4'h0, $past(i_live.watchdog_error_level, 2)})
    else $error("tally image wrong");
  a_mode_test: assert property (i_live.mode_test |-> ##2 o_programming_support_state == 8'h09)
    else $error("test mode code wrong");
  a_mode_prog: assert property (i_live.mode_programming && !i_live.mode_test |->
    ##2 o_programming_support_state == 8'h06)
    else $error("programming mode code wrong");
  a_mode_oper: assert property (!i_live.mode_programming && !i_live.mode_test |->
    ##2 o_programming_support_state == 8'h03)
    else $error("operating mode code wrong");
  a_option_live: assert property (!$past(i_reset) && !$past(i_reset, 2) |->
    o_hardware_option_detect == {$past(i_live.monitor_two_used, 2),
    $past(i_live.monitor_one_used, 2), 1'b0, $past(i_live.step_up_used, 2), 2'b00,
    $past(i_live.step_down2_used, 2), $past(i_live.switching_band_select, 2)})
    else $error("option image wrong");
  a_voltage_range: assert property (o_step_down2_output_setting[7:4] <= 4'h4 &&
    o_step_down2_output_setting[3:0] <= 4'h8)
    else $error("voltage code out of range");
  c_read: cover property (o_rvalid);
  c_err: cover property (o_addr_err);
  c_test: cover property (o_programming_support_state == 8'h09);
endmodule
bind pstat_regs pstat_regs_asserts i_chk (.i_clk_sys, .i_reset, .i_acc, .i_live, .o_rdata,
  .o_rvalid, .o_addr_err, .o_watchdog_fault_tally, .o_programming_support_state,
  .o_step_down2_output_setting, .o_hardware_option_detect);

/* File: verification/tb.sv */
// Testbench for the status bank with a host model.
// Assumes pstat_pkg compiled first.
`timescale 1ns/100ps
module tb
  import pstat_pkg::*;
;
  logic i_clk_sys;
  logic i_reset;
  pstat_acc_s acc;
  pstat_live_s live;
  logic [7:0] rdata, q, im0, im1, im2, im3;
  logic aerr, e, rvalid, v;
  int err_count;
  int total_checks;
  pstat_regs i_dut (.i_clk_sys, .i_reset, .i_acc(acc), .i_live(live), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_addr_err(aerr), .o_watchdog_fault_tally(im0),
    .o_programming_support_state(im1), .o_step_down2_output_setting(im2),
    .o_hardware_option_detect(im3));
  pstat_host i_host (.i_clk_sys, .i_rdata(rdata), .i_rvalid(rvalid), .i_addr_err(aerr),
    .o_acc(acc));
  // --------
  // Helpers
  // --------
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    i_host.xfer(1'b0, a, 8'h00, q, e, v);
    chk("read", x, q);
    chk("rvalid", 8'h01, {7'h00, v});
  endtask
  task automatic setl(input pstat_live_s v);
    @(posedge i_clk_sys);
    live <= v;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_live();
    setl({4'hF, 2'b00, 8'h48, 5'b0_1010});
    rd(7'h2A, 8'h0F);
    chk("wdt img", 8'h0F, im0);
    rd(7'h39, 8'h48);
    chk("b2 img", 8'h48, im2);
    rd(7'h3B, 8'h42);
    chk("hw img", 8'h42, im3);
    setl({4'h0, 2'b00, 8'h01, 5'b1_0101});
    rd(7'h2A, 8'h00);
    rd(7'h3B, 8'h91);
    // Codes past the table are refused, so the old setting stays
    setl({4'h0, 2'b00, 8'h59, 5'b1_0101});
    rd(7'h39, 8'h01);
    $display("test live done");
  endtask
  task automatic t_mode();
    logic [1:0] m [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    logic [7:0] x [4] = '{8'h06, 8'h09, 8'h09, 8'h03};
    for (int i = 0; i < 4; i++) begin
      setl({live[18:15], m[i], live[12:0]});
      rd(7'h37, x[i]);
      chk("mode img", x[i], im1);
    end
    $display("test mode done");
  endtask
  task automatic t_write();
    i_host.xfer(1'b1, 7'h39, 8'hFF, q, e, v);
    chk("wr err", 8'h00, {7'h00, e});
    chk("wr valid", 8'h00, {7'h00, v});
    rd(7'h39, 8'h01);
    i_host.xfer(1'b1, 7'h2B, 8'hFF, q, e, v);
    chk("bad wr", 8'h01, {7'h00, e});
    chk("bad wr valid", 8'h00, {7'h00, v});
    rd(7'h3C, 8'h00);
    chk("bad rd", 8'h01, {7'h00, e});
    $display("test write done");
  endtask
  // Mid-run reset; live codes past the table stay refused, so reset values remain
  task automatic t_reset();
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    chk("rst2", 8'h02, im2);
    chk("rst2", 8'hD3, im3);
    i_reset <= 1'b0;
    rd(7'h39, 8'h02);
    rd(7'h3B, 8'h91);
    $display("test reset again done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Clock, 5 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  // Main sequence; images checked while still in reset
  initial begin
    err_count = 0;
    total_checks = 0;
    i_reset = 1'b1;
    live = {4'h0, 2'b00, 8'h02, 5'b1_1011};
    repeat (10) @(posedge i_clk_sys);
    chk("rst", 8'h00, im0);
    chk("rst", 8'h03, im1);
    chk("rst", 8'h02, im2);
    chk("rst", 8'hD3, im3);
    $display("test reset done");
    i_reset <= 1'b0;
    t_live();
    t_mode();
    t_write();
    t_reset();
    stop_test();
  end
  // Watchdog, well past the roughly 70 cycles needed
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule
